// >>> src/tmr8_map.vh
`ifndef TMR8_MAP_VH
`define TMR8_MAP_VH
// register word addresses (byte address = 4 * index)
`define TMR8_IDX_CONTROL 2'h0
`define TMR8_IDX_BOUND 2'h1
`define TMR8_IDX_SCALER 2'h2
`define TMR8_IDX_COUNT 2'h3
// control fields
`define TMR8_CTL_SRC_HI 7
`define TMR8_CTL_SRC_LO 4
`define TMR8_CTL_OUT_HI 3
`define TMR8_CTL_OUT_LO 2
`define TMR8_CTL_MODE 1
// scaler fields
`define TMR8_SCL_PWM6 7
`define TMR8_SCL_PRE_HI 6
`define TMR8_SCL_PRE_LO 5
`define TMR8_SCL_DIV_HI 4
`define TMR8_SCL_DIV_LO 0
// clock source codes
`define TMR8_SRC_STOP 4'h0
`define TMR8_SRC_SYSCLK 4'h1
`define TMR8_SRC_EXT0 4'h2
`define TMR8_SRC_EXT1 4'h3
// output select codes
`define TMR8_OUT_FIRST 2'h2
`define TMR8_OUT_SECOND 2'h3
// reset values
`define TMR8_RST_BYTE 8'h00
// pre-scale terminal counts (divide by 1, 4, 16, 64)
`define TMR8_PRE_T1 6'h00
`define TMR8_PRE_T4 6'h03
`define TMR8_PRE_T16 6'h0F
`define TMR8_PRE_T64 6'h3F
// 6-bit pwm range mask
`define TMR8_PWM6_MASK 8'h3F
`endif

// >>> src/tmr8_divider.v
`include "tmr8_map.vh"

// pre-scaler followed by the 5-bit scaler; emits one-cycle count ticks
module tmr8_divider (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // source enable and settings
    input wire src_tick,
    input wire [1:0] pre_sel,
    input wire [4:0] div_val,
    // timer count clock as a tick
    output reg count_tick
);

reg [5:0] pre_reg;
reg [4:0] div_reg;
reg [5:0] pre_term;

always @*
begin
    case (pre_sel)
        2'h0: pre_term = `TMR8_PRE_T1;
        2'h1: pre_term = `TMR8_PRE_T4;
        2'h2: pre_term = `TMR8_PRE_T16;
        default: pre_term = `TMR8_PRE_T64;
    endcase
end

always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        pre_reg <= 6'h00;
        div_reg <= 5'h00;
        count_tick <= 1'b0;
    end
    else
    begin
        count_tick <= 1'b0;
        if (src_tick)
        begin
            if (pre_reg >= pre_term)
            begin
                pre_reg <= 6'h00;
                if (div_reg >= div_val)
                begin
                    div_reg <= 5'h00;
                    count_tick <= 1'b1;
                end
                else
                    div_reg <= div_reg + 5'h01;
            end
            else
                pre_reg <= pre_reg + 6'h01;
        end
    end
end

endmodule // tmr8_divider

// >>> src/tmr8_pwm.v
`include "tmr8_map.vh"

// Operation
// - in periodic mode the output has a 50 percent duty for any settings.
// - periodic frequency is source over 2*(bound+1)*prescale*(scaler+1).
// - control bits 7..4 choose the clock source of the divider chain.
// - scaler bits 6..5 pre-divide the source by 1, 4, 16 or 64.
// - scaler bits 4..0 divide further by their value plus one.
// - the 8-bit bound sets the period in periodic and duty in pwm modes.
// - 8-bit pwm runs at source/(256*pre*(scl+1)), duty (bound+1)/256.
// - 6-bit pwm runs at source/(64*pre*(scl+1)), duty (bound bits 5..0 + 1)/64.
// - source 0001 is the system clock, output 10 is the first pin, mode 0 periodic.
// - the counter counts up only and returns to zero on reaching the bound in periodic mode, or 255 (8-bit) or 63 (6-bit) in pwm modes.
// - software may write and read the count at any time.
// - control bits 3..2 route the waveform to the first or second pin.
module tmr8_pwm (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // avalon-mm slave
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // alternate clock sources, synchronous one-cycle enables
    input wire ext_src0_tick,
    input wire ext_src1_tick,
    // output pins
    output wire first_output_pin,
    output wire first_output_oe,
    output wire second_output_pin,
    output wire second_output_oe,
    // interrupt request pulse
    output reg timer8_irq
);

reg [7:0] timer8_control_reg;
reg [7:0] timer8_bound_reg;
reg [7:0] timer8_scaler_reg;
reg [7:0] timer8_count_reg;
reg [7:0] timer8_count_next;
reg wave_reg;
reg wave_next;
reg ack_reg;
reg src_tick;
reg wrap;
reg irq_next;
wire timer8_count_clock;
wire [1:0] word_idx;
wire req;
wire pwm_mode;
wire pwm6;
wire [7:0] full_top;

assign word_idx = avs_address[3:2];
assign req = avs_read | avs_write;
// one wait cycle per access, answer on the second cycle
assign avs_waitrequest = req & ~ack_reg;

assign pwm_mode = timer8_control_reg[`TMR8_CTL_MODE];
assign pwm6 = timer8_scaler_reg[`TMR8_SCL_PWM6];
assign full_top = pwm6 ? `TMR8_PWM6_MASK : 8'hFF;

always @*
begin
    case (timer8_control_reg[`TMR8_CTL_SRC_HI:`TMR8_CTL_SRC_LO])
        `TMR8_SRC_SYSCLK: src_tick = 1'b1;
        `TMR8_SRC_EXT0: src_tick = ext_src0_tick;
        `TMR8_SRC_EXT1: src_tick = ext_src1_tick;
        default: src_tick = 1'b0;
    endcase
end

tmr8_divider u_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .src_tick(src_tick),
    .pre_sel(timer8_scaler_reg[`TMR8_SCL_PRE_HI:`TMR8_SCL_PRE_LO]),
    .div_val(timer8_scaler_reg[`TMR8_SCL_DIV_HI:`TMR8_SCL_DIV_LO]),
    .count_tick(timer8_count_clock)
);

// counter, waveform and wrap detection
always @*
begin
    timer8_count_next = timer8_count_reg;
    wave_next = wave_reg;
    wrap = 1'b0;
    if (timer8_count_clock)
    begin
        if (!pwm_mode)
        begin
            if (timer8_count_reg >= timer8_bound_reg)
            begin
                timer8_count_next = `TMR8_RST_BYTE;
                wrap = 1'b1;
                wave_next = ~wave_reg;
            end
            else
                timer8_count_next = timer8_count_reg + 8'h01;
        end
        else
        begin
            if ((timer8_count_reg & full_top) >= full_top)
            begin
                timer8_count_next = `TMR8_RST_BYTE;
                wrap = 1'b1;
            end
            else
                timer8_count_next = (timer8_count_reg & full_top) + 8'h01;
        end
    end
    if (pwm_mode)
        wave_next = ((timer8_count_next & full_top) <=
                     (timer8_bound_reg & full_top));
    // software write of the count takes priority over counting
    if (avs_write && ack_reg && word_idx == `TMR8_IDX_COUNT
        && avs_byteenable[0])
        timer8_count_next = avs_writedata[7:0];
    irq_next = wrap;
end

always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        timer8_control_reg <= `TMR8_RST_BYTE;
        timer8_bound_reg <= `TMR8_RST_BYTE;
        timer8_scaler_reg <= `TMR8_RST_BYTE;
        timer8_count_reg <= `TMR8_RST_BYTE;
        wave_reg <= 1'b0;
        ack_reg <= 1'b0;
        timer8_irq <= 1'b0;
        avs_readdata <= 32'h00000000;
    end
    else
    begin
        timer8_count_reg <= timer8_count_next;
        wave_reg <= wave_next;
        timer8_irq <= irq_next;
        ack_reg <= req & ~ack_reg;
        if (avs_write && ack_reg && avs_byteenable[0])
        begin
            case (word_idx)
                `TMR8_IDX_CONTROL: timer8_control_reg <= avs_writedata[7:0];
                `TMR8_IDX_BOUND: timer8_bound_reg <= avs_writedata[7:0];
                `TMR8_IDX_SCALER: timer8_scaler_reg <= avs_writedata[7:0];
                default: ;
            endcase
        end
        if (avs_read && !ack_reg)
        begin
            case (word_idx)
                `TMR8_IDX_CONTROL:
                    avs_readdata <= {24'h000000, timer8_control_reg};
                `TMR8_IDX_BOUND:
                    avs_readdata <= {24'h000000, timer8_bound_reg};
                `TMR8_IDX_SCALER:
                    avs_readdata <= {24'h000000, timer8_scaler_reg};
                default:
                    avs_readdata <= {24'h000000, timer8_count_reg};
            endcase
        end
    end
end

// pin routing
assign first_output_oe = (timer8_control_reg[`TMR8_CTL_OUT_HI:`TMR8_CTL_OUT_LO]
                          == `TMR8_OUT_FIRST);
assign second_output_oe = (timer8_control_reg[`TMR8_CTL_OUT_HI:`TMR8_CTL_OUT_LO]
                           == `TMR8_OUT_SECOND);
assign first_output_pin = wave_reg & first_output_oe;
assign second_output_pin = wave_reg & second_output_oe;

endmodule // tmr8_pwm

// >>> tb/tmr8_monitor.sv
module tmr8_monitor (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // register bus
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // sources, pins, request
    input wire ext_src0_tick,
    input wire ext_src1_tick,
    input wire first_output_pin,
    input wire first_output_oe,
    input wire second_output_pin,
    input wire second_output_oe,
    input wire timer8_irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // one wait state, then the answer
    sequence s_ack;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    sequence s_wrap;
        ##[0:1] timer8_irq;
    endsequence
    property p_rd;
        $rose(avs_read) |-> s_ack;
    endproperty
    a_rd: assert property (p_rd) else $error("read ack");
    property p_wr;
        $rose(avs_write) |-> s_ack;
    endproperty
    a_wr: assert property (p_wr) else $error("write ack");
    property p_idle;
        !(avs_read || avs_write) |-> !avs_waitrequest;
    endproperty
    a_idle: assert property (p_idle) else $error("idle wait");
    property p_gate1;
        !first_output_oe |-> !first_output_pin;
    endproperty
    a_gate1: assert property (p_gate1) else $error("pin1 gate");
    property p_gate2;
        !second_output_oe |-> !second_output_pin;
    endproperty
    a_gate2: assert property (p_gate2) else $error("pin2 gate");
    property p_excl;
        !(first_output_oe && second_output_oe);
    endproperty
    a_excl: assert property (p_excl) else $error("both pins");
    // a rising edge away from register writes marks a counter wrap
    property p_rise1;
        $rose(first_output_pin) && $stable(first_output_oe)
            && !$past(avs_write) && !$past(avs_write, 2) |-> s_wrap;
    endproperty
    a_rise1: assert property (p_rise1) else $error("pin1 irq");
    property p_rise2;
        $rose(second_output_pin) && $stable(second_output_oe)
            && !$past(avs_write) && !$past(avs_write, 2) |-> s_wrap;
    endproperty
    a_rise2: assert property (p_rise2) else $error("pin2 irq");
endmodule // tmr8_monitor

bind tmr8_pwm tmr8_monitor tmr8_monitor_i (.*);

// >>> tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, sel = 0;
    logic ext_src0_tick = 0, ext_src1_tick = 0;
    logic [1:0] ph = 0;
    logic [3:0] avs_address = 0, avs_byteenable = 0;
    logic [31:0] avs_writedata = 0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, first_output_pin, first_output_oe;
    wire second_output_pin, second_output_oe, timer8_irq;
    wire pin = sel ? second_output_pin : first_output_pin;
    int failures = 0, compares = 0;
    tmr8_pwm tmr8_pwm_i (.sys_clk, .rst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .ext_src0_tick, .ext_src1_tick,
        .first_output_pin, .first_output_oe, .second_output_pin,
        .second_output_oe, .timer8_irq);
    initial forever #10 sys_clk = ~sys_clk;
    // source 2 ticks every other cycle
    always @(posedge sys_clk) ext_src0_tick <= ~ext_src0_tick;
    // source 3 ticks every fourth cycle
    always @(posedge sys_clk)
    begin
        ph <= ph + 2'h1;
        ext_src1_tick <= (ph == 2'h3);
    end
    task end_sim;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, e);
        compares++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %0t got %0h want %0h", $time, g, e);
        end
    endtask
    task automatic bus(input bit w, input [1:0] i, input [7:0] d,
        input bit e, output [31:0] q);
        int n = 0;
        @(posedge sys_clk);
        avs_address <= {i, 2'b00};
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= {3'h0, e};
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 50)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 50)
        begin
            failures++;
            $display("ERROR %0t bus timeout", $time);
        end
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task automatic wrt(input [1:0] i, input [7:0] d);
        logic [31:0] q;
        bus(1, i, d, 1, q);
    endtask
    task automatic rdc(input [1:0] i, input [7:0] e);
        logic [31:0] q;
        bus(0, i, 8'h00, 1, q);
        chk(q, {24'h0, e});
    endtask
    task automatic lvl(input bit v, output int n);
        n = 0;
        while (pin !== v && n < 5000)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    // program, then time one high and one low phase in cycles
    task automatic wave(input [7:0] c, s, b, input int hi, lo);
        int n, h, l;
        wrt(2, s);
        wrt(1, b);
        wrt(3, 8'h00);
        wrt(0, c);
        sel = c[2];
        lvl(0, n);
        lvl(1, n);
        lvl(0, h);
        lvl(1, l);
        chk({first_output_oe, second_output_oe}, c[2] ? 1 : 2);
        chk(h, hi);
        chk(l, lo);
    endtask
    task automatic t_regs;
        logic [31:0] q;
        wrt(0, 8'hF0);
        wrt(1, 8'hA5);
        wrt(2, 8'h5A);
        wrt(3, 8'h3C);
        bus(1, 1, 8'h11, 0, q);
        rdc(0, 8'hF0);
        rdc(1, 8'hA5);
        rdc(2, 8'h5A);
        rdc(3, 8'h3C);
        $display("t_regs done");
    endtask
    task automatic t_period;
        for (int p = 0; p < 4; p++)
            wave(8'h18, {1'b0, p[1:0], 5'd1}, 1, 4 << 2 * p, 4 << 2 * p);
        wave(8'h28, 8'h00, 1, 4, 4);
        wave(8'h3C, 8'h00, 1, 8, 8);
        $display("t_period done");
    endtask
    task automatic t_pwm;
        wave(8'h1E, 8'h00, 9, 10, 246);
        wave(8'h1A, 8'h80, 0, 1, 63);
        $display("t_pwm done");
    endtask
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1;
        t_regs;
        t_period;
        t_pwm;
        end_sim;
    end
    initial
    begin
        #1000000;
        failures++;
        end_sim;
    end
endmodule // testbench
